// File: bench/cbc_core_model.sv
`timescale 1ns/10ps
// cipher core stand-in: answers a launch after a short delay with data xor the low 128 key bits
module cbc_core_model (
   input wire aclk,
   input wire core_start,
   input wire [127:0] core_din,
   input wire [255:0] core_key,
   output reg core_done = 1'b0,
   output reg [127:0] core_dout = 128'h0
);
   reg [2:0] cnt = 3'h0;
   reg [127:0] res = 128'h0;
   // result is valid only beside the done pulse, a moving pattern otherwise
   always @(posedge aclk) begin
      core_done <= 1'b0;
      core_dout <= ~core_dout;
      if (core_start) begin
         cnt <= 3'h3;
         res <= core_din ^ core_key[127:0];
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
         if (cnt == 3'h1) begin
            core_done <= 1'b1;
            core_dout <= res;
         end
      end
   end
endmodule // cbc_core_model

// File: bench/cbc_dataflow_properties.sv
`timescale 1ns/10ps
// timing of bus answers and of core launch and completion
module cbc_dataflow_properties (
   input logic aclk,
   input logic aresetn,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic [31:0] s_axi_rdata,
   input logic core_start,
   input logic core_encrypt,
   input logic core_done,
   input logic done_irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   start_pulse_a: assert property (core_start |=> !core_start)
      else $error("core start longer than one cycle");
   irq_cause_a: assert property (done_irq |-> $past(core_done))
      else $error("done irq without core done");
   irq_pulse_a: assert property (done_irq |=> !done_irq)
      else $error("done irq longer than one cycle");
   dir_kept_a: assert property ($changed(core_encrypt) |-> core_start)
      else $error("direction changed outside a launch");
   // both halves taken at one edge; the write lands one edge later and the answer rises at that same edge, seen at the next
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && !s_axi_arready) else $error("no read answer");
   read_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
endmodule // cbc_dataflow_properties
bind cbc_dataflow cbc_dataflow_properties chk_u (.*);

// File: bench/cbc_dataflow_test.sv
`timescale 1ns/10ps
`include "cbc_defines.vh"
module cbc_dataflow_test;
   reg aclk = 1'b0;
   reg aresetn = 1'b0;
   reg [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hF;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, core_key_size;
   wire [31:0] s_axi_rdata;
   wire core_start, core_encrypt, core_done, done_irq;
   wire [127:0] core_din, core_dout;
   wire [255:0] core_key;
   integer num_errors = 0, compares = 0, i, k;
   reg [7:0] rb;
   reg [127:0] c1;
   localparam [127:0] P1 = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
   localparam [127:0] P2 = 128'h1122334455667788990011223344AA55;
   localparam [127:0] IV = 128'hA1B2C3D4E5F60718293A4B5C6D7E8F90;
   localparam [255:0] KY = {P2 ^ IV, P1 ^ 128'h5A};
   cbc_dataflow dut_u (.*);
   cbc_core_model core_u (.*);
   initial forever #50 aclk = ~aclk;
   task chk(input [255:0] got, input [255:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // one bus transfer: write when wr is set, else read into rb
   task bus(input wr, input [4:0] a, input [7:0] d, input [1:0] er);
      reg ha, hw, hr, f;
      reg [1:0] rs;
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_araddr <= a;
         s_axi_wdata <= {24'h0, d};
         s_axi_awvalid <= wr;
         s_axi_wvalid <= wr;
         s_axi_bready <= wr;
         s_axi_arvalid <= !wr;
         s_axi_rready <= !wr;
         f = 1'b0;
         // the wait ends when the answer arrives; only the watchdog ends one that hangs
         while (!f) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hr = s_axi_arvalid && s_axi_arready;
            f = wr ? s_axi_bvalid : s_axi_rvalid;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            rb = s_axi_rdata[7:0];
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hr) s_axi_arvalid <= 1'b0;
         end
         s_axi_bready <= 1'b0;
         s_axi_rready <= 1'b0;
         chk(rs, er);
      end
   endtask
   // interleaved data, chaining and key bytes, then the extra key bytes
   task blk(input [127:0] dat, input [127:0] chn, input wc, input integer nk);
      for (i = 0; i < nk; i = i + 1) begin
         if (i < 16) begin
            bus(1'b1, `CBC_OFS_BLOCK_INPUT, dat[127-8*i -: 8], `CBC_RESP_OKAY);
            if (wc) bus(1'b1, `CBC_OFS_CHAIN_INPUT, chn[127-8*i -: 8], `CBC_RESP_OKAY);
         end
         bus(1'b1, `CBC_OFS_KEY_INPUT, KY[255-8*i -: 8], `CBC_RESP_OKAY);
      end
   endtask
   task wdone;
      integer n;
      begin
         n = 0;
         do begin
            @(negedge aclk);
            n = n + 1;
         end while (done_irq !== 1'b1 && n < 200);
         chk(done_irq, 1'b1);
      end
   endtask
   task rres(input [127:0] exp);
      for (k = 0; k < 16; k = k + 1) begin
         bus(1'b0, `CBC_OFS_RESULT_OUTPUT, 8'h00, `CBC_RESP_OKAY);
         chk(rb, exp[127-8*k -: 8]);
      end
   endtask
   task complete_run;
      begin
         $display("compares %0d errors %0d", compares, num_errors);
         if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
         end else begin
            $display("DONE - FAIL");
         end
         $finish;
      end
   endtask
   // main sequence: reset values, two chained encryptions, decryption, key sizes
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      bus(1'b0, `CBC_OFS_BLOCK_CONFIG, 8'h00, `CBC_RESP_OKAY);
      chk(rb, `CBC_RST_BLOCK_CONFIG);
      bus(1'b1, 5'h18, 8'h01, `CBC_RESP_SLVERR);
      bus(1'b0, 5'h01, 8'h00, `CBC_RESP_SLVERR);
      bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h00, `CBC_RESP_OKAY);
      bus(1'b1, `CBC_OFS_DATA_FLOW, `CBC_FLOW_XOR_IN, `CBC_RESP_OKAY);
      bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h0C, `CBC_RESP_OKAY);
      blk(P1, IV, 1'b1, 16);
      wdone;
      chk(core_din, P1 ^ IV);
      chk(core_encrypt, 1'b1);
      c1 = P1 ^ IV ^ KY[255:128];
      rres(c1);
      bus(1'b0, `CBC_OFS_BLOCK_CONFIG, 8'h00, `CBC_RESP_OKAY);
      chk(rb, 8'h2C);
      blk(P2, IV, 1'b0, 16);
      wdone;
      chk(core_din, P2 ^ c1);
      bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h00, `CBC_RESP_OKAY);
      bus(1'b1, `CBC_OFS_DATA_FLOW, `CBC_FLOW_XOR_OUT, `CBC_RESP_OKAY);
      bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h08, `CBC_RESP_OKAY);
      blk(P2, IV, 1'b1, 16);
      wdone;
      chk(core_din, P2);
      chk(core_encrypt, 1'b0);
      rres(P2 ^ KY[255:128] ^ IV);
      // second decryption block chains the first block's input ciphertext
      blk(P1, IV, 1'b0, 16);
      wdone;
      rres(P1 ^ KY[255:128] ^ P2);
      for (k = 1; k < 3; k = k + 1) begin
         bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h00, `CBC_RESP_OKAY);
         bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h0C | k[7:0], `CBC_RESP_OKAY);
         blk(P1, IV, 1'b0, 16 + 8 * k);
         wdone;
         chk(core_key_size, k);
      end
      chk(core_key, KY);
      // plain flow with the reserved key size code: no xor, 16 key bytes suffice
      bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h00, `CBC_RESP_OKAY);
      bus(1'b1, `CBC_OFS_DATA_FLOW, 8'h00, `CBC_RESP_OKAY);
      bus(1'b1, `CBC_OFS_BLOCK_CONFIG, 8'h0F, `CBC_RESP_OKAY);
      blk(P1, IV, 1'b1, 16);
      wdone;
      chk(core_din, P1);
      chk(core_key_size, 2'h3);
      rres(P1 ^ KY[255:128]);
      complete_run;
   end
   // watchdog well beyond the roughly 1500 cycles the sequence needs
   initial begin
      #(100 * 20000);
      num_errors = num_errors + 1;
      complete_run;
   end
endmodule // cbc_dataflow_test

// File: design/cbc_dataflow.v
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "cbc_defines.vh"
module cbc_dataflow (
   input wire aclk,
   input wire aresetn,
   input wire [4:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [4:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg core_start,
   output reg core_encrypt,
   output reg [1:0] core_key_size,
   output reg [127:0] core_din,
   output reg [255:0] core_key,
   input wire core_done,
   input wire [127:0] core_dout,
   output reg done_irq
);
   reg [4:0] aw_addr;
   reg aw_got;
   reg [7:0] w_byte;
   reg w_lane;
   reg w_got;
   reg [5:0] cfg;
   reg [1:0] flow;
   reg [127:0] data_buf;
   reg [127:0] chain_buf;
   reg [127:0] chain_next;
   reg [127:0] result_buf;
   reg [255:0] key_buf;
   reg [4:0] data_cnt;
   reg [4:0] chain_cnt;
   reg [5:0] key_cnt;
   reg [4:0] rd_idx;
   reg [5:0] key_need;
   reg [7:0] out_byte;
   reg [7:0] rd_byte;
   wire do_write;
   wire wr_cfg;
   wire wr_flow;
   wire wr_data;
   wire wr_chain;
   wire wr_key;
   wire rd_hit;
   wire rd_result;
   wire ready_to_go;
   wire busy;
   assign do_write = aw_got && w_got && !s_axi_bvalid;
   assign wr_cfg = do_write && w_lane && aw_addr == {1'b0, `CBC_OFS_BLOCK_CONFIG};
   assign wr_flow = do_write && w_lane && aw_addr == {1'b0, `CBC_OFS_DATA_FLOW};
   assign wr_data = do_write && w_lane && aw_addr == {1'b0, `CBC_OFS_BLOCK_INPUT};
   assign wr_chain = do_write && w_lane && aw_addr == {1'b0, `CBC_OFS_CHAIN_INPUT};
   assign wr_key = do_write && w_lane && aw_addr == `CBC_OFS_KEY_INPUT;
   assign rd_hit = s_axi_arvalid && s_axi_arready;
   assign rd_result = rd_hit && s_axi_araddr == `CBC_OFS_RESULT_OUTPUT;
   assign busy = cfg[`CBC_BC_BUSY];
   // key bytes needed per size code; the reserved code falls back to 128 bits
   always @* begin
      case (cfg[`CBC_BC_KS_HI:`CBC_BC_KS_LO])
         `CBC_KS_192: key_need = `CBC_KEY_BYTES_192;
         `CBC_KS_256: key_need = `CBC_KEY_BYTES_256;
         default: key_need = `CBC_KEY_BYTES_128;
      endcase
   end
   // a block starts once enabled and all bytes it needs have arrived
   assign ready_to_go = cfg[`CBC_BC_EN] && !busy && !core_start
      && data_cnt == `CBC_BLOCK_BYTES && key_cnt >= key_need;
   // result byte as read; xor-on-output flow folds the chaining byte in
   always @* begin
      out_byte = result_buf[127 - {rd_idx[3:0], 3'b000} -: 8];
      if (flow == `CBC_FLOW_XOR_OUT) begin
         out_byte = out_byte ^ chain_buf[127 - {rd_idx[3:0], 3'b000} -: 8];
      end
   end
   // register read mux
   always @* begin
      rd_byte = 8'h00;
      case (s_axi_araddr)
         {1'b0, `CBC_OFS_BLOCK_CONFIG}: rd_byte = {2'b00, cfg};
         {1'b0, `CBC_OFS_DATA_FLOW}: rd_byte = {6'b000000, flow};
         `CBC_OFS_RESULT_OUTPUT: rd_byte = out_byte;
         default: rd_byte = 8'h00;
      endcase
   end
   // axi4-lite write channels, taken in either order, one write at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CBC_RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 5'h00;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            if (aw_addr[1:0] != 2'b00 || aw_addr > `CBC_OFS_RESULT_OUTPUT) begin
               s_axi_bresp <= `CBC_RESP_SLVERR;
            end else begin
               s_axi_bresp <= `CBC_RESP_OKAY;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end
   // axi4-lite read channel; a result read advances the byte pointer
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CBC_RESP_OKAY;
      end else begin
         if (rd_hit) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > `CBC_OFS_RESULT_OUTPUT) begin
               s_axi_rresp <= `CBC_RESP_SLVERR;
            end else begin
               s_axi_rresp <= `CBC_RESP_OKAY;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
   // configuration, byte collection, core launch and completion
   always @(posedge aclk) begin
      if (!aresetn) begin
         cfg <= `CBC_RST_BLOCK_CONFIG;
         flow <= `CBC_RST_DATA_FLOW;
         data_buf <= 128'h0;
         chain_buf <= 128'h0;
         chain_next <= 128'h0;
         result_buf <= 128'h0;
         key_buf <= 256'h0;
         data_cnt <= 5'h00;
         chain_cnt <= 5'h00;
         key_cnt <= 6'h00;
         rd_idx <= 5'h00;
         core_start <= 1'b0;
         core_encrypt <= 1'b0;
         core_key_size <= `CBC_KS_128;
         core_din <= 128'h0;
         core_key <= 256'h0;
         done_irq <= 1'b0;
      end else begin
         core_start <= 1'b0;
         done_irq <= 1'b0;
         if (wr_flow) begin
            flow <= w_byte[1:0];
         end
         if (wr_cfg) begin
            // writing zero here clears busy, the byte counters and the read pointer as well
            cfg[3:0] <= w_byte[3:0];
            if (!w_byte[`CBC_BC_DONE]) begin
               cfg[`CBC_BC_DONE] <= 1'b0;
            end
            if (w_byte == 8'h00) begin
               cfg[`CBC_BC_BUSY] <= 1'b0;
               data_cnt <= 5'h00;
               chain_cnt <= 5'h00;
               key_cnt <= 6'h00;
               rd_idx <= 5'h00;
            end
         end
         if (wr_data && data_cnt != `CBC_BLOCK_BYTES) begin
            data_buf <= {data_buf[119:0], w_byte};
            data_cnt <= data_cnt + 5'h01;
         end
         if (wr_chain) begin
            chain_buf <= {chain_buf[119:0], w_byte};
            chain_cnt <= (chain_cnt == `CBC_BLOCK_BYTES) ? 5'h01 : chain_cnt + 5'h01;
         end
         if (wr_key && key_cnt != `CBC_KEY_BYTES_256) begin
            key_buf <= {key_buf[247:0], w_byte};
            key_cnt <= key_cnt + 6'h01;
         end
         if (rd_result) begin
            if (rd_idx == `CBC_BLOCK_BYTES - 5'h01) begin
               rd_idx <= 5'h00;
               // decrypt chaining: next block xors with this block's ciphertext
               if (flow == `CBC_FLOW_XOR_OUT && chain_cnt == 5'h00) begin
                  chain_buf <= chain_next;
               end
               chain_cnt <= 5'h00;
            end else begin
               rd_idx <= rd_idx + 5'h01;
            end
         end
         if (ready_to_go) begin
            core_start <= 1'b1;
            core_encrypt <= cfg[`CBC_BC_ENC];
            core_key_size <= cfg[`CBC_BC_KS_HI:`CBC_BC_KS_LO];
            core_key <= key_buf;
            if (flow == `CBC_FLOW_XOR_IN) begin
               core_din <= data_buf ^ chain_buf;
            end else begin
               core_din <= data_buf;
            end
            chain_next <= data_buf;
            cfg[`CBC_BC_BUSY] <= 1'b1;
            data_cnt <= 5'h00;
            key_cnt <= 6'h00;
            chain_cnt <= 5'h00;
         end
         if (core_done && busy) begin
            // done is set after the clear above so a same-cycle clear loses
            result_buf <= core_dout;
            cfg[`CBC_BC_BUSY] <= 1'b0;
            cfg[`CBC_BC_DONE] <= 1'b1;
            done_irq <= 1'b1;
            rd_idx <= 5'h00;
            if (flow == `CBC_FLOW_XOR_IN) begin
               chain_buf <= core_dout;
            end
         end
      end
   end
endmodule // cbc_dataflow

// File: design/cbc_defines.vh
`ifndef CBC_DEFINES_VH
`define CBC_DEFINES_VH
// register byte offsets on the axi4-lite bus
`define CBC_OFS_BLOCK_CONFIG 4'h0
`define CBC_OFS_DATA_FLOW 4'h4
`define CBC_OFS_BLOCK_INPUT 4'h8
`define CBC_OFS_CHAIN_INPUT 4'hC
`define CBC_OFS_KEY_INPUT 5'h10
`define CBC_OFS_RESULT_OUTPUT 5'h14
// block_config field positions
`define CBC_BC_KS_LO 0
`define CBC_BC_KS_HI 1
`define CBC_BC_ENC 2
`define CBC_BC_EN 3
`define CBC_BC_BUSY 4
`define CBC_BC_DONE 5
// data_flow_config codes
`define CBC_FLOW_PLAIN 2'h0
`define CBC_FLOW_XOR_IN 2'h1
`define CBC_FLOW_XOR_OUT 2'h2
// key size codes and byte counts
`define CBC_KS_128 2'h0
`define CBC_KS_192 2'h1
`define CBC_KS_256 2'h2
`define CBC_KEY_BYTES_128 6'h10
`define CBC_KEY_BYTES_192 6'h18
`define CBC_KEY_BYTES_256 6'h20
`define CBC_BLOCK_BYTES 5'h10
// reset values
`define CBC_RST_BLOCK_CONFIG 6'h00
`define CBC_RST_DATA_FLOW 2'h0
// axi responses
`define CBC_RESP_OKAY 2'h0
`define CBC_RESP_SLVERR 2'h2
`endif
